// File: rtl/hbs_defines.svh
// register offsets, field positions, reset values for the code and packet status bank
// assumes: included by bare name, no other definitions of these macros
`ifndef HBS_DEFINES_SVH
`define HBS_DEFINES_SVH
`define HBS_OFF_RX_CODE      8'h04
`define HBS_OFF_RX_FIFO      8'h05
`define HBS_OFF_TX_STATUS    8'h06
`define HBS_BIT_LATCHED      7
`define HBS_BIT_NOW          6
`define HBS_BIT_TX_EMPTY     2
`define HBS_BIT_TX_FULL      1
`define HBS_BIT_TX_UNDERRUN  0
`define HBS_BIT_MASK_CODE    7
`define HBS_CODE_RESET       6'h3F
`define HBS_FIFO_DEPTH       64
`define HBS_FIFO_AW          6
`endif

// File: rtl/hbs_pkg.sv
// types shared by the status bank, the far-end stand-in and the bench
// assumes: nothing beyond the compiler
package hbs_pkg;
  typedef struct packed {
    logic       valid;
    logic [5:0] code;
  } hbs_code_t;
  typedef struct packed {
    logic       rd;
    logic [7:0] addr;
  } hbs_host_t;
  typedef enum logic [2:0] {
    HBS_TX_IDLE  = 3'b001,
    HBS_TX_MSG   = 3'b010,
    HBS_TX_ABORT = 3'b100
  } hbs_tx_state_t;
endpackage

// File: rtl/hbs_rx_mem.sv
// receive packet store: byte memory with registered read data
// assumes: single clock, caller never writes when full nor reads when empty
`timescale 1ns/1ps
module hbs_rx_mem #(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic         CLK,
  input  wire logic         NRST,
  input  wire logic         WR_EN,
  input  wire logic [AW-1:0] WR_ADDR,
  input  wire logic [7:0]   WR_DATA,
  input  wire logic [AW-1:0] RD_ADDR,
  output logic      [7:0]   RD_DATA
);
  logic [7:0] mem [DEPTH];
  always_ff @(posedge CLK) begin
    if (WR_EN) begin
      mem[WR_ADDR] <= WR_DATA;
    end
  end
  // read data always registered, so the port value is one cycle behind the pointer
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      RD_DATA <= 8'h00;
    end else begin
      RD_DATA <= mem[RD_ADDR];
    end
  end
endmodule

// File: rtl/hbs_status_regs.sv
// code detector and packet controller status register bank
// assumes: host read strobe is one cycle per access, detector and packet engine share CLK
//
// How it works
// - real-time code seen flag follows detector
// - bit 7 latches the real-time flag
// - reading code register clears latched flag unless the real-time flag is still set
// - codeword bits 5..0, first bit in 0
// - codeword updates only on verified codes
// - reset loads codeword with all ones
// - underrun held until transmit status read
// - detector change of state raises event, masked only at CODE_IRQ
`timescale 1ns/1ps
`include "hbs_defines.svh"
module hbs_status_regs #(
  parameter int DEPTH = `HBS_FIFO_DEPTH,
  parameter int AW    = `HBS_FIFO_AW
) (
  input  wire logic               CLK,
  input  wire logic               NRST,
  input  wire hbs_pkg::hbs_host_t HOST,
  output logic      [7:0]         RD_DATA,
  input  wire logic               CODE_NOW,
  input  wire hbs_pkg::hbs_code_t CODE_IN,
  input  wire logic               RX_WR,
  input  wire logic [7:0]         RX_BYTE,
  output logic                    RX_READY,
  input  wire logic               TX_PUSH,
  input  wire logic               TX_MSG_END,
  input  wire logic               TX_POP,
  output logic                    TX_ABORT,
  input  wire logic               CODE_MASK,
  output logic                    CODE_EVENT,
  output logic                    CODE_IRQ
);
  import hbs_pkg::*;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  wire rd_code = HOST.rd && (HOST.addr == `HBS_OFF_RX_CODE);
  wire rd_fifo = HOST.rd && (HOST.addr == `HBS_OFF_RX_FIFO);
  wire rd_tx   = HOST.rd && (HOST.addr == `HBS_OFF_TX_STATUS);

  // ----------------------------------------
  // receive code register
  // ----------------------------------------
  logic [5:0] code_q;
  logic       now_q;
  logic       latched_q;
  logic       event_q;
  wire        latched_d = CODE_NOW | (latched_q & ~rd_code);
  wire        change    = CODE_NOW != now_q;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      code_q    <= `HBS_CODE_RESET;
      now_q     <= 1'b0;
      latched_q <= 1'b0;
      event_q   <= 1'b0;
    end else begin
      if (CODE_IN.valid) begin
        code_q <= CODE_IN.code;
      end
      now_q     <= CODE_NOW;
      latched_q <= latched_d;
      event_q   <= change | (event_q & ~rd_code);
    end
  end
  assign CODE_EVENT = event_q;
  assign CODE_IRQ   = event_q & CODE_MASK;

  // ----------------------------------------
  // receive packet store
  // ----------------------------------------
  logic [AW:0]   rx_wp_q;
  logic [AW:0]   rx_rp_q;
  logic [7:0]    rx_rdata;
  wire           rx_empty = rx_wp_q == rx_rp_q;
  wire           rx_full  = (rx_wp_q[AW] != rx_rp_q[AW]) && (rx_wp_q[AW-1:0] == rx_rp_q[AW-1:0]);
  wire           rx_wen   = RX_WR && !rx_full;
  wire           rx_adv   = rd_fifo && !rx_empty;
  wire [AW:0]    rx_rp_d  = rx_rp_q + (AW+1)'(rx_adv);
  assign RX_READY = !rx_full;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rx_wp_q <= '0;
      rx_rp_q <= '0;
    end else begin
      rx_wp_q <= rx_wp_q + (AW+1)'(rx_wen);
      rx_rp_q <= rx_rp_d;
    end
  end
  // pointer one ahead lets the registered output already hold the oldest byte
  hbs_rx_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem (
    .CLK     (CLK),
    .NRST    (NRST),
    .WR_EN   (rx_wen),
    .WR_ADDR (rx_wp_q[AW-1:0]),
    .WR_DATA (RX_BYTE),
    .RD_ADDR (rx_rp_d[AW-1:0]),
    .RD_DATA (rx_rdata)
  );

  // ----------------------------------------
  // transmit status
  // ----------------------------------------
  logic [AW:0]   tx_cnt_q;
  logic          udr_q;
  hbs_tx_state_t tx_st_q;
  hbs_tx_state_t tx_st_d;
  wire           tx_empty = tx_cnt_q == '0;
  wire           tx_full  = tx_cnt_q == (AW+1)'(DEPTH);
  wire           tx_in    = TX_PUSH && !tx_full;
  wire           tx_out   = TX_POP && !tx_empty;
  // running dry without a message end is the underrun
  wire           dry      = (tx_st_q == HBS_TX_MSG) && TX_POP && tx_empty && !TX_MSG_END;
  always_comb begin
    tx_st_d = tx_st_q;
    unique case (tx_st_q)
      HBS_TX_IDLE: begin
        if (tx_out) begin
          tx_st_d = HBS_TX_MSG;
        end
      end
      HBS_TX_MSG: begin
        if (TX_MSG_END) begin
          tx_st_d = HBS_TX_IDLE;
        end else if (dry) begin
          tx_st_d = HBS_TX_ABORT;
        end
      end
      HBS_TX_ABORT: begin
        tx_st_d = HBS_TX_IDLE;
      end
      default: tx_st_d = HBS_TX_IDLE;
    endcase
  end
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      tx_cnt_q <= '0;
      udr_q    <= 1'b0;
      tx_st_q  <= HBS_TX_IDLE;
    end else begin
      tx_cnt_q <= tx_cnt_q + (AW+1)'(tx_in) - (AW+1)'(tx_out);
      udr_q    <= dry | (udr_q & ~rd_tx);
      tx_st_q  <= tx_st_d;
    end
  end
  assign TX_ABORT = tx_st_q == HBS_TX_ABORT;

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // unassigned transmit status bits read zero; the host ignores them anyway
  wire [7:0] code_word = {latched_q, now_q, code_q};
  wire [7:0] tx_word   = {5'h00, tx_empty, tx_full, udr_q};
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      RD_DATA <= 8'h00;
    end else if (rd_code) begin
      RD_DATA <= code_word;
    end else if (rd_fifo) begin
      RD_DATA <= rx_rdata;
    end else if (rd_tx) begin
      RD_DATA <= tx_word;
    end else if (HOST.rd) begin
      RD_DATA <= 8'h00;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_now;
    @(posedge CLK) disable iff (!NRST) 1'b1 |=> now_q == $past(CODE_NOW);
  endproperty
  a_now: assert property (p_now) else $error("real-time flag lags");
  property p_latch;
    @(posedge CLK) disable iff (!NRST) now_q |-> latched_q;
  endproperty
  a_latch: assert property (p_latch) else $error("latched flag missed");
  property p_clr;
    @(posedge CLK) disable iff (!NRST) rd_code && !CODE_NOW |=> !latched_q;
  endproperty
  a_clr: assert property (p_clr) else $error("latched flag not cleared");
  property p_code;
    @(posedge CLK) disable iff (!NRST) rd_code |=> RD_DATA[5:0] == $past(code_q);
  endproperty
  a_code: assert property (p_code) else $error("codeword read wrong");
  property p_hold;
    @(posedge CLK) disable iff (!NRST) !CODE_IN.valid |=> $stable(code_q);
  endproperty
  a_hold: assert property (p_hold) else $error("codeword changed");
  property p_udr;
    @(posedge CLK) disable iff (!NRST) udr_q && !rd_tx |=> udr_q;
  endproperty
  a_udr: assert property (p_udr) else $error("underrun lost");
  property p_abort;
    @(posedge CLK) disable iff (!NRST) dry |=> TX_ABORT && udr_q;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort on underrun");
  property p_adv;
    @(posedge CLK) disable iff (!NRST) rd_fifo && !rx_empty |=> rx_rp_q == $past(rx_rp_q) + 1'b1;
  endproperty
  a_adv: assert property (p_adv) else $error("fifo not advanced");
  property p_evt;
    @(posedge CLK) disable iff (!NRST) change |=> CODE_EVENT;
  endproperty
  a_evt: assert property (p_evt) else $error("change event missed");
  property p_evt_clr;
    @(posedge CLK) disable iff (!NRST) rd_code && !change |=> !CODE_EVENT;
  endproperty
  a_evt_clr: assert property (p_evt_clr) else $error("change event not cleared");
  property p_load;
    @(posedge CLK) disable iff (!NRST) CODE_IN.valid |=> code_q == $past(CODE_IN.code);
  endproperty
  a_load: assert property (p_load) else $error("verified code not loaded");
  property p_tx_read;
    @(posedge CLK) disable iff (!NRST) rd_tx |=> RD_DATA == $past(tx_word);
  endproperty
  a_tx_read: assert property (p_tx_read) else $error("transmit status read wrong");
  property p_rx_stall;
    @(posedge CLK) disable iff (!NRST) rd_fifo && rx_empty |=> rx_rp_q == $past(rx_rp_q);
  endproperty
  a_rx_stall: assert property (p_rx_stall) else $error("empty store advanced");
endmodule

// File: dv/hbs_far_end.sv
// far-end stand-in: code detector and packet engine pins
// assumes: bench calls its tasks; pins change at falling edges only
`timescale 1ns/1ps
module hbs_far_end (
  input  wire logic      CLK,
  output logic           CODE_NOW,
  output hbs_pkg::hbs_code_t CODE_IN,
  output logic           RX_WR,
  output logic [7:0]     RX_BYTE,
  output logic           TX_POP,
  output logic           TX_MSG_END
);
  import hbs_pkg::*;
  initial begin
    {CODE_NOW, CODE_IN, RX_WR, RX_BYTE, TX_POP, TX_MSG_END} = '0;
  end
  // idle data is inverted so a stale value never passes by luck
  task automatic code(input logic now, input logic vld, input logic [5:0] c);
    @(negedge CLK);
    CODE_NOW = now;
    CODE_IN = '{vld, c};
    @(negedge CLK);
    CODE_IN = '{1'b0, ~c};
  endtask
  task automatic put_rx(input logic [7:0] b);
    @(negedge CLK);
    RX_WR = 1'b1;
    RX_BYTE = b;
    @(negedge CLK);
    RX_WR = 1'b0;
    RX_BYTE = ~b;
  endtask
  task automatic pop(input logic fin);
    @(negedge CLK);
    TX_POP = !fin;
    TX_MSG_END = fin;
    @(negedge CLK);
    TX_POP = 1'b0;
    TX_MSG_END = 1'b0;
  endtask
endmodule

// File: dv/hbs_status_regs_test.sv
// self-checking bench for the code and packet status bank
// assumes: far-end stand-in drives the engine pins
`timescale 1ns/1ps
module hbs_status_regs_test;
  import hbs_pkg::*;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  hbs_host_t  host = '0;
  logic [7:0] rd_data;
  logic       code_now;
  hbs_code_t  code_in;
  logic       rx_wr;
  logic [7:0] rx_byte;
  logic       rx_ready;
  logic       tx_push = 1'b0;
  logic       tx_msg_end;
  logic       tx_pop;
  logic       tx_abort;
  logic       code_mask = 1'b0;
  logic       code_event;
  logic       code_irq;
  logic [7:0] d;
  int         errors = 0;
  int         samples_checked = 0;
  always #2.5 clk = ~clk;
  hbs_status_regs i_hbs_status_regs (.CLK(clk), .NRST(nrst), .HOST(host), .RD_DATA(rd_data),
    .CODE_NOW(code_now), .CODE_IN(code_in), .RX_WR(rx_wr), .RX_BYTE(rx_byte), .RX_READY(rx_ready),
    .TX_PUSH(tx_push), .TX_MSG_END(tx_msg_end), .TX_POP(tx_pop), .TX_ABORT(tx_abort),
    .CODE_MASK(code_mask), .CODE_EVENT(code_event), .CODE_IRQ(code_irq));
  hbs_far_end i_hbs_far_end (.CLK(clk), .CODE_NOW(code_now), .CODE_IN(code_in), .RX_WR(rx_wr),
    .RX_BYTE(rx_byte), .TX_POP(tx_pop), .TX_MSG_END(tx_msg_end));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    host = '{1'b1, a};
    @(negedge clk);
    host = '{1'b0, a};
    @(negedge clk);
    d = rd_data;
  endtask
  task automatic push(input int n);
    @(negedge clk);
    tx_push = 1'b1;
    repeat (n) @(negedge clk);
    tx_push = 1'b0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_code;
    i_hbs_far_end.code(1'b1, 1'b1, 6'h2D);
    repeat (2) @(negedge clk);
    rd(8'h04);
    check(d, 8'hED);
    i_hbs_far_end.code(1'b0, 1'b0, 6'h11);
    repeat (2) @(negedge clk);
    check({7'h0, code_irq}, 8'h00);
    code_mask = 1'b1;
    #1 check({7'h0, code_irq}, 8'h01);
    rd(8'h04);
    check(d, 8'hAD);
    rd(8'h04);
    check(d, 8'h2D);
    check({7'h0, code_event}, 8'h00);
  endtask
  task automatic t_rx;
    i_hbs_far_end.put_rx(8'hA5);
    i_hbs_far_end.put_rx(8'h3C);
    repeat (2) @(negedge clk);
    rd(8'h05);
    check(d, 8'hA5);
    rd(8'h05);
    check(d, 8'h3C);
    // read of the empty store must not move the pointer
    rd(8'h05);
    i_hbs_far_end.put_rx(8'h5A);
    repeat (2) @(negedge clk);
    rd(8'h05);
    check(d, 8'h5A);
    for (int i = 0; i < 64; i++) begin
      i_hbs_far_end.put_rx(8'(i));
    end
    check({7'h0, rx_ready}, 8'h00);
    // dropped when full, else it would land on the oldest byte
    i_hbs_far_end.put_rx(8'hFF);
    rd(8'h05);
    check(d, 8'h00);
    check({7'h0, rx_ready}, 8'h01);
    rd(8'h05);
    check(d, 8'h01);
  endtask
  task automatic t_tx;
    logic seen;
    seen = 1'b0;
    push(2);
    rd(8'h06);
    check(d & 8'h07, 8'h00);
    repeat (3) i_hbs_far_end.pop(1'b0);
    // dry pop mid-message must abort within a few cycles
    for (int i = 0; i < 4; i++) begin
      seen |= tx_abort;
      @(negedge clk);
    end
    check({7'h0, seen}, 8'h01);
    rd(8'h06);
    check(d & 8'h07, 8'h05);
    rd(8'h06);
    check(d & 8'h07, 8'h04);
    // a clean message end keeps a later empty pop from counting as underrun
    push(1);
    i_hbs_far_end.pop(1'b0);
    i_hbs_far_end.pop(1'b1);
    i_hbs_far_end.pop(1'b0);
    rd(8'h06);
    check(d & 8'h07, 8'h04);
    // one push past full must be ignored
    push(65);
    rd(8'h06);
    check(d & 8'h07, 8'h02);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    rd(8'h04);
    check(d, 8'h3F);
    rd(8'h07);
    check(d, 8'h00);
    t_code();
    // reset in mid-run must reload the codeword
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    rd(8'h04);
    check(d, 8'h3F);
    t_rx();
    t_tx();
    print_verdict();
  end
endmodule
